// ===== rtl/irq_status_nmi.sv
// Interrupt controller status readback and NMI logic
//
// Behaviour
// - 8-bit request register, unmasked; acknowledge clears its highest-priority unmasked set bit
// - 8-bit in-service register set on acknowledge, cleared by end-of-service command
// - Word three with read-register bit picks request (0) or in-service (1)
// - Read selection persists across reads until next word three write
// - Poll and read-register both set: next command-port read is a poll read
// - After the init word sequence the selection returns to request register
// - Reads of the mask port return the mask register
// - Low system-error line sets the system-error detect flop
// - Low channel-check line sets the channel-check detect flop
// - NMI status port: bit 6 channel-check, bit 7 system-error detect
// - Bits 3 and 2 disable channel-check and system-error, clearing detects
// - Enable port bit 7 gates all sources, detects left untouched
// - Detect set while disabled raises NMI once global enable returns
// - NMI is a level held while any enabled source is pending
// - Global disable then enable drives NMI low then high again
// - Each mask bit masks only its own request line
`timescale 1ns/10ps
`default_nettype none
module irq_status_nmi (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Host I/O port access
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  output logic [7:0] io_rdata_o,
  output logic io_rdata_valid_o,
  // Interrupt requests and acknowledge
  input wire logic [7:0] irq_i,
  input wire logic irq_ack_i,
  output logic [7:0] ack_level_o,
  output logic ack_valid_o,
  output logic irq_pending_o,
  // Error pins, active low
  input wire logic pci_serr_n_i,
  input wire logic isa_chk_n_i,
  // Non-maskable interrupt output
  output logic nmi_o
);
  import irq_nmi_pkg::*;

  typedef enum logic [1:0] {INIT_IDLE, INIT_WAIT} init_state_t;

  logic [7:0] request_status_reg;
  logic [7:0] request_status_nxt;
  logic [7:0] in_service_reg;
  logic [7:0] in_service_nxt;
  logic [7:0] line_mask_reg;
  logic [7:0] line_mask_nxt;
  logic [7:0] irq_prev_r;
  logic [7:0] irq_prev_nxt;
  logic read_select_r;
  logic read_select_nxt;
  logic poll_pending_r;
  logic poll_pending_nxt;
  init_state_t init_state_r;
  init_state_t init_state_nxt;
  logic [1:0] init_count_r;
  logic [1:0] init_count_nxt;
  logic [7:0] nmi_ctrl_r;
  logic [7:0] nmi_ctrl_nxt;
  logic [7:0] nmi_enable_r;
  logic [7:0] nmi_enable_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [7:0] ack_level_r;
  logic [7:0] ack_level_nxt;
  logic ack_valid_r;
  logic ack_valid_nxt;
  logic nmi_r;
  logic nmi_nxt;
  logic serr_level;
  logic chk_level;
  logic serr_detect;
  logic chk_detect;
  logic [7:0] irq_rise;
  logic [7:0] top_request;
  logic [2:0] top_index;
  logic top_found;
  logic [7:0] top_service;
  logic take_ack;
  logic poll_read;
  logic wr_cmd;
  logic wr_data;

  // Pin synchronisers
  input_sync serr_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pci_serr_n_i),
    .level_o(serr_level)
  );
  input_sync chk_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(isa_chk_n_i),
    .level_o(chk_level)
  );

  // Detect flops, cleared by their disable bits
  nmi_source serr_src (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .err_level_n_i(serr_level),
    .disable_i(nmi_ctrl_r[SERR_DISABLE_BIT]),
    .detect_o(serr_detect)
  );
  nmi_source chk_src (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .err_level_n_i(chk_level),
    .disable_i(nmi_ctrl_r[CHK_DISABLE_BIT]),
    .detect_o(chk_detect)
  );

  // Port decode; bit 4 separates init words from operation words
  assign wr_cmd = io_wr_i && (io_addr_i == ADDR_CMD_LOW);
  assign wr_data = io_wr_i && (io_addr_i == ADDR_MASK);
  assign poll_read = io_rd_i && (io_addr_i == ADDR_CMD_LOW) && poll_pending_r;
  assign take_ack = irq_ack_i || poll_read;
  assign irq_rise = irq_i & ~irq_prev_r;

  // Priority pick: line 0 highest, unmasked lines only for service
  always_comb begin
    top_index = 3'h0;
    top_found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (request_status_reg[i] && !line_mask_reg[i]) begin
        top_index = i[2:0];
        top_found = 1'b1;
      end
    end
    top_request = top_found ? (8'h01 << top_index) : 8'h00;
    top_service = 8'h00;
    for (int j = 7; j >= 0; j--) begin
      if (in_service_reg[j]) begin
        top_service = 8'h00;
        top_service[j] = 1'b1;
      end
    end
  end

  // Interrupt controller state next values
  always_comb begin
    request_status_nxt = request_status_reg;
    in_service_nxt = in_service_reg;
    line_mask_nxt = line_mask_reg;
    read_select_nxt = read_select_r;
    poll_pending_nxt = poll_pending_r;
    init_state_nxt = init_state_r;
    init_count_nxt = init_count_r;
    irq_prev_nxt = irq_i;
    ack_level_nxt = ack_level_r;
    ack_valid_nxt = 1'b0;
    // Acknowledge moves the top request into service
    if (take_ack && top_found) begin
      request_status_nxt = request_status_nxt & ~top_request;
      in_service_nxt = in_service_nxt | top_request;
    end
    if (take_ack) begin
      ack_level_nxt = top_found ? (POLL_VALID_FLAG | {5'h00, top_index}) : POLL_IDLE_WORD;
      ack_valid_nxt = 1'b1;
      poll_pending_nxt = 1'b0;
    end
    // New edges set request bits; a set in the clearing cycle wins
    request_status_nxt = request_status_nxt | irq_rise;
    if (wr_cmd && io_wdata_i[INIT_BIT]) begin
      init_state_nxt = INIT_WAIT;
      init_count_nxt = 2'(INIT_WORDS - 1);
      in_service_nxt = 8'h00;
      line_mask_nxt = 8'h00;
      read_select_nxt = 1'b0;
      poll_pending_nxt = 1'b0;
    end else if (init_state_r == INIT_WAIT && wr_data) begin
      // Remaining init words go to the data port
      if (init_count_r == 2'h1) begin
        init_state_nxt = INIT_IDLE;
        read_select_nxt = 1'b0;
      end
      init_count_nxt = init_count_r - 2'h1;
    end else if (wr_data) begin
      line_mask_nxt = io_wdata_i;
    end else if (wr_cmd && io_wdata_i[WORD_THREE_BIT]) begin
      if (io_wdata_i[POLL_BIT] && io_wdata_i[READ_REGISTER_BIT]) begin
        poll_pending_nxt = 1'b1;
      end else if (io_wdata_i[READ_REGISTER_BIT]) begin
        read_select_nxt = io_wdata_i[READ_SELECT_BIT];
      end
    end else if (wr_cmd && io_wdata_i[END_SERVICE_BIT]) begin
      in_service_nxt = in_service_nxt & ~top_service;
    end
    case (init_state_r)
      INIT_IDLE: ;
      INIT_WAIT: ;
      default: init_state_nxt = INIT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      request_status_reg <= 8'h00;
      in_service_reg <= 8'h00;
      line_mask_reg <= MASK_RESET;
      read_select_r <= 1'b0;
      poll_pending_r <= 1'b0;
      init_state_r <= INIT_IDLE;
      init_count_r <= 2'h0;
      irq_prev_r <= 8'h00;
      ack_level_r <= 8'h00;
      ack_valid_r <= 1'b0;
    end else begin
      request_status_reg <= request_status_nxt;
      in_service_reg <= in_service_nxt;
      line_mask_reg <= line_mask_nxt;
      read_select_r <= read_select_nxt;
      poll_pending_r <= poll_pending_nxt;
      init_state_r <= init_state_nxt;
      init_count_r <= init_count_nxt;
      irq_prev_r <= irq_prev_nxt;
      ack_level_r <= ack_level_nxt;
      ack_valid_r <= ack_valid_nxt;
    end
  end

  // NMI control registers and output level
  always_comb begin
    nmi_ctrl_nxt = nmi_ctrl_r;
    nmi_enable_nxt = nmi_enable_r;
    if (io_wr_i && io_addr_i == ADDR_NMI_STATUS) begin
      nmi_ctrl_nxt = io_wdata_i & 8'h0F;
    end
    if (io_wr_i && io_addr_i == ADDR_NMI_ENABLE) begin
      nmi_enable_nxt = io_wdata_i;
    end
    // Level, not pulse: host toggles global disable to get a new edge
    nmi_nxt = !nmi_enable_r[GLOBAL_DISABLE_BIT] &&
              ((serr_detect && !nmi_ctrl_r[SERR_DISABLE_BIT]) ||
               (chk_detect && !nmi_ctrl_r[CHK_DISABLE_BIT]));
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nmi_ctrl_r <= NMI_CTRL_RESET;
      nmi_enable_r <= NMI_ENABLE_RESET;
      nmi_r <= 1'b0;
    end else begin
      nmi_ctrl_r <= nmi_ctrl_nxt;
      nmi_enable_r <= nmi_enable_nxt;
      nmi_r <= nmi_nxt;
    end
  end

  // Read data registered one cycle after the read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (io_rd_i) begin
      rvalid_nxt = 1'b1;
      if (poll_read) begin
        rdata_nxt = top_found ? (POLL_VALID_FLAG | {5'h00, top_index}) : POLL_IDLE_WORD;
      end else if (io_addr_i == ADDR_CMD_LOW) begin
        rdata_nxt = read_select_r ? in_service_reg : request_status_reg;
      end else if (io_addr_i == ADDR_MASK) begin
        rdata_nxt = line_mask_reg;
      end else if (io_addr_i == ADDR_NMI_STATUS) begin
        rdata_nxt = nmi_ctrl_r;
        rdata_nxt[SERR_STATUS_BIT] = serr_detect;
        rdata_nxt[CHK_STATUS_BIT] = chk_detect;
      end else if (io_addr_i == ADDR_NMI_ENABLE) begin
        rdata_nxt = nmi_enable_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign io_rdata_o = rdata_r;
  assign io_rdata_valid_o = rvalid_r;
  assign ack_level_o = ack_level_r;
  assign ack_valid_o = ack_valid_r;
  assign irq_pending_o = top_found;
  assign nmi_o = nmi_r;
endmodule
`default_nettype wire

// ===== rtl/irq_nmi_pkg.sv
// Package: port addresses, command word fields and reset values
package irq_nmi_pkg;
  localparam logic [7:0] ADDR_CMD_LOW = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h21;
  localparam logic [7:0] ADDR_NMI_STATUS = 8'h61;
  localparam logic [7:0] ADDR_NMI_ENABLE = 8'h70;
  // Low command port: bit 4 marks an init word, bit 3 marks word three
  localparam int INIT_BIT = 4;
  localparam int WORD_THREE_BIT = 3;
  localparam int POLL_BIT = 2;
  localparam int READ_REGISTER_BIT = 1;
  localparam int READ_SELECT_BIT = 0;
  // End-of-service command: bit 5 set, word-two form
  localparam int END_SERVICE_BIT = 5;
  // NMI port bits
  localparam int CHK_STATUS_BIT = 6;
  localparam int SERR_STATUS_BIT = 7;
  localparam int CHK_DISABLE_BIT = 3;
  localparam int SERR_DISABLE_BIT = 2;
  localparam int GLOBAL_DISABLE_BIT = 7;
  localparam int INIT_WORDS = 4;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] NMI_CTRL_RESET = 8'h00;
  localparam logic [7:0] NMI_ENABLE_RESET = 8'h80;
  localparam logic [7:0] POLL_IDLE_WORD = 8'h00;
  localparam logic [7:0] POLL_VALID_FLAG = 8'h80;
endpackage

// ===== rtl/input_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module input_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic level_r;
  logic level_nxt;

  // Stage one only feeds stage two; the filter looks at two and three
  always_comb begin
    stage_nxt = {stage_r[1:0], pin_i};
    level_nxt = (stage_r[2] == stage_r[1]) ? stage_r[2] : level_r;
  end

  // Idle high, as the pins are active low
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_r <= 3'h7;
      level_r <= 1'b1;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;
endmodule
`default_nettype wire

// ===== rtl/nmi_source.sv
// One NMI source: low level of the error pin sets a detect flop
`timescale 1ns/10ps
`default_nettype none
module nmi_source (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Filtered active-low error level and per-source disable
  input wire logic err_level_n_i,
  input wire logic disable_i,
  output logic detect_o
);
  logic detect_r;
  logic detect_nxt;

  // Disabled source is held clear; a low error line sets the flop
  always_comb begin
    if (disable_i) begin
      detect_nxt = 1'b0;
    end else if (!err_level_n_i) begin
      detect_nxt = 1'b1;
    end else begin
      detect_nxt = detect_r;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      detect_r <= 1'b0;
    end else begin
      detect_r <= detect_nxt;
    end
  end

  assign detect_o = detect_r;
endmodule
`default_nettype wire

// ===== bench/irq_status_nmi_asserts.sv
// Checker for the status readback and NMI block ports
`timescale 1ns/10ps
`default_nettype none
module irq_status_nmi_asserts
  import irq_nmi_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Host port
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rdata_valid_o,
  // Requests, errors and NMI
  input wire logic [7:0] irq_i,
  input wire logic irq_ack_i,
  input wire logic [7:0] ack_level_o,
  input wire logic ack_valid_o,
  input wire logic irq_pending_o,
  input wire logic pci_serr_n_i,
  input wire logic isa_chk_n_i,
  input wire logic nmi_o
);
  logic [3:0] ctl_r;
  logic [3:0] ctl_nxt;
  logic mapped;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of the stored NMI control nibble
  always_comb begin
    ctl_nxt = ctl_r;
    if (io_wr_i && io_addr_i == ADDR_NMI_STATUS) begin
      ctl_nxt = io_wdata_i[3:0];
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_r <= NMI_CTRL_RESET[3:0];
    end else begin
      ctl_r <= ctl_nxt;
    end
  end
  // Decoded ports; anything else must read as zero
  assign mapped = io_addr_i inside {ADDR_CMD_LOW, ADDR_MASK, ADDR_NMI_STATUS, ADDR_NMI_ENABLE};
  read_answer_a: assert property (io_rd_i |=> io_rdata_valid_o)
    else $error("read not answered");
  valid_cause_a: assert property (io_rdata_valid_o |-> $past(io_rd_i))
    else $error("read valid without read");
  data_hold_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (io_rd_i && !mapped |=> io_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  ctl_nibble_a: assert property (io_rd_i && io_addr_i == ADDR_NMI_STATUS |=> io_rdata_o[3:0] == ctl_r)
    else $error("control nibble wrong");
  nmi_flags_a: assert property (nmi_o && !$past(io_wr_i) && io_rd_i && io_addr_i == ADDR_NMI_STATUS |=> io_rdata_o[7:6] != 2'b00)
    else $error("NMI high but no source flagged");
  global_off_a: assert property (io_wr_i && io_addr_i == ADDR_NMI_ENABLE && io_wdata_i[7] |-> ##2 !nmi_o)
    else $error("NMI not gated off");
  sources_off_a: assert property (io_wr_i && io_addr_i == ADDR_NMI_STATUS && io_wdata_i[3:2] == 2'b11 |-> ##3 !nmi_o [*2])
    else $error("NMI with all sources disabled");
  ack_idle_a: assert property (irq_ack_i && !irq_pending_o |=> !ack_level_o[7])
    else $error("acknowledge with nothing pending flagged valid");
  ack_taken_a: assert property (irq_ack_i && irq_pending_o |=> ack_level_o[7] && ack_valid_o)
    else $error("pending request not acknowledged");
endmodule
bind irq_status_nmi irq_status_nmi_asserts u_irq_status_nmi_asserts (.clk_i, .sys_rst_i,
  .io_addr_i, .io_wdata_i, .io_wr_i, .io_rd_i, .io_rdata_o, .io_rdata_valid_o, .irq_i,
  .irq_ack_i, .ack_level_o, .ack_valid_o, .irq_pending_o, .pci_serr_n_i, .isa_chk_n_i, .nmi_o);
`default_nettype wire

// ===== bench/host_model.sv
// Host processor model: port cycles and edge-sensitive NMI input
`timescale 1ns/10ps
`default_nettype none
module host_model
  import irq_nmi_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Port cycle toward the block
  output logic [7:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_wr_o,
  output logic io_rd_o,
  // Answers from the block
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rdata_valid_i,
  input wire logic nmi_i
);
  int nmi_edges = 0;
  logic nmi_q = 1'b0;
  initial begin
    io_addr_o = 8'h00;
    io_wdata_o = 8'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
  end
  // Processor only notices rising edges, so a held level hides new sources
  always @(posedge clk_i) begin
    if (nmi_i && !nmi_q) nmi_edges++;
    nmi_q <= nmi_i;
  end
  // Idle bus shows inverted last values so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(negedge clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(negedge clk_i);
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    n = 0;
    while (io_rdata_valid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    d = (n < 4) ? io_rdata_i : 8'hxx;
  endtask
  // Service exit: global off then on to make a fresh edge
  task automatic rearm();
    wr(ADDR_NMI_ENABLE, 8'h80);
    wr(ADDR_NMI_ENABLE, 8'h00);
  endtask
endmodule
`default_nettype wire

// ===== bench/irq_status_nmi_tb_top.sv
// Testbench for the status readback and NMI block
`timescale 1ns/10ps
`default_nettype none
module irq_status_nmi_tb_top;
  import irq_nmi_pkg::*;
  logic clk_i, sys_rst_i, io_wr_i, io_rd_i, io_rdata_valid_o, irq_ack_i;
  logic ack_valid_o, irq_pending_o, pci_serr_n_i, isa_chk_n_i, nmi_o;
  logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, irq_i, ack_level_o, d;
  int err_count = 0;
  int tests_run = 0;
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  irq_status_nmi u_irq_status_nmi (.clk_i, .sys_rst_i, .io_addr_i, .io_wdata_i, .io_wr_i,
    .io_rd_i, .io_rdata_o, .io_rdata_valid_o, .irq_i, .irq_ack_i, .ack_level_o, .ack_valid_o,
    .irq_pending_o, .pci_serr_n_i, .isa_chk_n_i, .nmi_o);
  host_model u_host_model (.clk_i, .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i),
    .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_rdata_i(io_rdata_o),
    .io_rdata_valid_i(io_rdata_valid_o), .nmi_i(nmi_o));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, d);
    chk(n, e, d);
  endtask
  // Error pin low long enough to pass the synchroniser, then settle
  task automatic pin(input bit chk_pin);
    @(negedge clk_i);
    if (chk_pin) isa_chk_n_i = 1'b0;
    else pci_serr_n_i = 1'b0;
    repeat (6) @(negedge clk_i);
    isa_chk_n_i = 1'b1;
    pci_serr_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic ack(input logic [7:0] e);
    @(negedge clk_i);
    irq_ack_i = 1'b1;
    @(negedge clk_i);
    irq_ack_i = 1'b0;
    chk("ack level", e, {ack_level_o[7], e[7] ? ack_level_o[6:0] : 7'h00});
  endtask
  task automatic test_done();
    $display("Checks run %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    sys_rst_i = 1'b1;
    irq_i = 8'h00;
    irq_ack_i = 1'b0;
    pci_serr_n_i = 1'b1;
    isa_chk_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rchk("mask", ADDR_MASK, MASK_RESET);
    rchk("nmi status", ADDR_NMI_STATUS, NMI_CTRL_RESET);
    rchk("nmi enable", ADDR_NMI_ENABLE, NMI_ENABLE_RESET);
    rchk("unmapped", 8'h33, 8'h00);
    u_host_model.wr(ADDR_CMD_LOW, 8'h10);
    repeat (3) u_host_model.wr(ADDR_MASK, 8'h00);
    u_host_model.wr(ADDR_MASK, 8'h08);
    rchk("mask", ADDR_MASK, 8'h08);
    @(negedge clk_i);
    irq_i = 8'h28;
    rchk("request", ADDR_CMD_LOW, 8'h28);
    chk("pending", 8'h01, {7'h00, irq_pending_o});
    ack(8'h85);
    u_host_model.wr(ADDR_CMD_LOW, 8'h0A);
    rchk("request", ADDR_CMD_LOW, 8'h08);
    u_host_model.wr(ADDR_CMD_LOW, 8'h0B);
    repeat (2) rchk("in service", ADDR_CMD_LOW, 8'h20);
    u_host_model.wr(ADDR_CMD_LOW, 8'h20);
    rchk("in service", ADDR_CMD_LOW, 8'h00);
    u_host_model.wr(ADDR_MASK, 8'h00);
    u_host_model.wr(ADDR_CMD_LOW, 8'h0F);
    rchk("poll", ADDR_CMD_LOW, 8'h83);
    rchk("in service", ADDR_CMD_LOW, 8'h08);
    ack(8'h00);
    u_host_model.wr(ADDR_NMI_ENABLE, 8'h00);
    pin(0);
    chk("nmi", 8'h01, {7'h00, nmi_o});
    rchk("nmi status", ADDR_NMI_STATUS, 8'h80);
    pin(1);
    rchk("nmi status", ADDR_NMI_STATUS, 8'hC0);
    chk("nmi edges", 8'h01, 8'(u_host_model.nmi_edges));
    u_host_model.rearm();
    repeat (3) @(negedge clk_i);
    chk("nmi edges", 8'h02, 8'(u_host_model.nmi_edges));
    u_host_model.wr(ADDR_NMI_ENABLE, 8'h80);
    repeat (3) @(negedge clk_i);
    chk("nmi gated", 8'h00, {7'h00, nmi_o});
    rchk("nmi status", ADDR_NMI_STATUS, 8'hC0);
    u_host_model.wr(ADDR_NMI_ENABLE, 8'h00);
    repeat (3) @(negedge clk_i);
    chk("nmi back", 8'h01, {7'h00, nmi_o});
    u_host_model.wr(ADDR_NMI_STATUS, 8'h04);
    rchk("nmi status", ADDR_NMI_STATUS, 8'h44);
    u_host_model.wr(ADDR_NMI_STATUS, 8'h0C);
    rchk("nmi status", ADDR_NMI_STATUS, 8'h0C);
    chk("nmi cleared", 8'h00, {7'h00, nmi_o});
    pin(0);
    rchk("nmi status", ADDR_NMI_STATUS, 8'h0C);
    u_host_model.wr(ADDR_NMI_STATUS, 8'h00);
    pin(1);
    rchk("nmi status", ADDR_NMI_STATUS, 8'h40);
    // Re-init while in-service is selected: selection must fall back to requests
    irq_i = 8'h29;
    u_host_model.wr(ADDR_CMD_LOW, 8'h10);
    repeat (3) u_host_model.wr(ADDR_MASK, 8'h00);
    rchk("request", ADDR_CMD_LOW, 8'h01);
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rchk("nmi status", ADDR_NMI_STATUS, NMI_CTRL_RESET);
    test_done();
  end
endmodule
`default_nettype wire
